// File: bench/codec_ctrl_regs_chk.sv
// Port assertions for the codec control register bank.
// Assumes it is bound into codec_ctrl_regs and sees only that module's ports.
`timescale 1ns/1ps

module codec_ctrl_regs_chk
	import codec_ctrl_pkg::*;
#(
	parameter longint CalCycles = CAL_CYCLES
) (
	input wire logic                clk,
	input wire logic                rstn,
	input wire logic                spiMode,
	input wire logic [2:0]          regAddr,
	input wire logic                regWrEn,
	input wire logic [7:0]          regWrData,
	input wire logic                regRdEn,
	input wire logic [7:0]          regRdData,
	input wire logic [SAMPLE_W-1:0] adcSampleOutLeft,
	input wire logic                adcPowerDown,
	input wire logic                leftHighpassDefeat,
	input wire logic                rightHighpassDefeat,
	input wire logic [1:0]          deemphasisSelect,
	input wire logic                bitClockPolarity,
	input wire logic [1:0]          outputFormat,
	input wire logic [1:0]          inputFormat,
	input wire logic [1:0]          masterClockRatio,
	input wire logic                calibrationRunning,
	input wire logic [7:0]          leftAppliedAtten,
	input wire logic                leftDacMuted
);
	logic        leftMute_q;
	logic        soft_q;
	logic [21:0] calCnt_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	// Mirror of the mute and level-change method bits
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			leftMute_q <= 1'b0;
			soft_q     <= 1'b0;
		end else if (regWrEn && regAddr == ADDR_ADC) begin
			leftMute_q <= regWrData[ADC_MUTE_BIT0];
		end else if (regWrEn && regAddr == ADDR_DAC) begin
			soft_q <= regWrData[DAC_SOFT_BIT];
		end
	end

	// Length of the current calibration run
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			calCnt_q <= '0;
		end else begin
			calCnt_q <= calibrationRunning ? calCnt_q + 22'h1 : '0;
		end
	end

	a_power_down: assert property (regWrEn && regAddr == ADDR_ADC
		|=> adcPowerDown == $past(regWrData[7])) else $error("power-down level wrong");
	a_highpass_bits: assert property (regWrEn && regAddr == ADDR_ADC
		|=> {rightHighpassDefeat, leftHighpassDefeat} == $past(regWrData[6:5]))
		else $error("high-pass defeat wrong");
	a_port_fields: assert property (regWrEn && regAddr == ADDR_PORT
		|=> {deemphasisSelect, bitClockPolarity, outputFormat, inputFormat}
		== $past(regWrData[6:0])) else $error("port format fields wrong");
	a_clock_ratio: assert property (regWrEn && regAddr == ADDR_MCLK
		|=> masterClockRatio == $past(regWrData[1:0])) else $error("clock ratio wrong");
	a_spi_read: assert property (spiMode && regRdEn |=> regRdData == 8'h00)
		else $error("read in write-only mode not zero");
	a_reserved_read: assert property (!spiMode && regRdEn && regAddr == ADDR_RESERVED
		|=> regRdData == 8'h00) else $error("reserved slot not zero");
	a_busy_read: assert property (!spiMode && regRdEn && regAddr == ADDR_ADC
		|=> regRdData[1] == $past(calibrationRunning)) else $error("busy bit wrong");
	a_adc_silence: assert property (leftMute_q && $past(leftMute_q)
		|-> adcSampleOutLeft == '0) else $error("muted channel not silent");
	a_ramp_step: assert property (!soft_q && !$past(soft_q) && $changed(leftAppliedAtten)
		|-> leftAppliedAtten == $past(leftAppliedAtten) + 8'h01
		|| $past(leftAppliedAtten) == leftAppliedAtten + 8'h01) else $error("ramp not one step");
	a_mute_flag: assert property (leftDacMuted == (leftAppliedAtten >= MUTE_CODE))
		else $error("mute flag wrong");
	a_att_ceiling: assert property (leftAppliedAtten <= MUTE_CODE)
		else $error("level beyond mute code");
	a_cal_length: assert property ($fell(calibrationRunning)
		|-> calCnt_q >= CalCycles - 1 && calCnt_q <= CalCycles + 1)
		else $error("calibration length wrong");

	c_muted: cover property ($rose(leftDacMuted));
	c_status_read: cover property (!spiMode && regRdEn && regAddr == ADDR_STATUS);
	c_cal_done: cover property ($fell(calibrationRunning));
endmodule

bind codec_ctrl_regs codec_ctrl_regs_chk #(.CalCycles(CalCycles)) codec_ctrl_regs_chk_i (
	.clk, .rstn, .spiMode, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
	.adcSampleOutLeft, .adcPowerDown, .leftHighpassDefeat, .rightHighpassDefeat,
	.deemphasisSelect, .bitClockPolarity, .outputFormat, .inputFormat, .masterClockRatio,
	.calibrationRunning, .leftAppliedAtten, .leftDacMuted
);

// File: bench/codec_ctrl_regs_test.sv
// Self-checking bench for the codec control register bank.
// Assumes the frame_source partner and the bound port checker.
`timescale 1ns/1ps

module codec_ctrl_regs_test
	import codec_ctrl_pkg::*;
;
	logic                clk = 1'b0;
	logic                rstn, spiMode, regWrEn, regRdEn, resetPinN, clockFaultIn;
	logic                frameLrClock, leftDacMuted, rightDacMuted, calibrationRunning;
	logic                adcPowerDown, leftHighpassDefeat, rightHighpassDefeat, bitClockPolarity;
	logic [1:0]          deemphasisSelect, outputFormat, inputFormat, masterClockRatio, srcMode;
	logic [2:0]          regAddr, adcPeakInLeft, adcPeakInRight;
	logic [7:0]          regWrData, regRdData, leftAppliedAtten, rightAppliedAtten;
	logic [8:0]          f, g;
	logic [SAMPLE_W-1:0] dacL, dacR, adcInL, adcInR, adcOutL, adcOutR;
	logic [7:0]          mask [6] = '{8'h00, 8'h00, 8'hFC, 8'h7F, 8'h03, 8'h7B};
	logic [2:0]          addr [6] = '{3'h0, 3'h6, 3'h1, 3'h5, 3'h7, 3'h2};
	int                  mismatches = 0, checks = 0, n, t;
	int                  per [4] = '{8, 4, 16, 32};

	always #12.5 clk = ~clk;

	codec_ctrl_regs #(.CalCycles(20)) codec_ctrl_regs_i (
		.clk, .rstn, .spiMode, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
		.frameLrClock, .resetPinN, .clockFaultIn, .dacSampleLeft(dacL), .dacSampleRight(dacR),
		.adcSampleInLeft(adcInL), .adcSampleInRight(adcInR), .adcPeakInLeft, .adcPeakInRight,
		.adcSampleOutLeft(adcOutL), .adcSampleOutRight(adcOutR), .adcPowerDown,
		.leftHighpassDefeat, .rightHighpassDefeat, .deemphasisSelect, .bitClockPolarity,
		.outputFormat, .inputFormat, .masterClockRatio, .calibrationRunning,
		.leftAppliedAtten, .rightAppliedAtten, .leftDacMuted, .rightDacMuted
	);

	frame_source frame_source_i (
		.mode(srcMode), .frameLrClock(frameLrClock), .sampleLeft(dacL), .sampleRight(dacR)
	);

	// Verdict and end of run
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// Compare seen against expected
	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One register write strobe
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		@(posedge clk);
	endtask

	// One register read strobe, then compare the registered data
	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		@(posedge clk);
		chk($sformatf("register %0d", a), regRdData, exp);
	endtask

	// One cycle of a bounded wait; running out ends the run
	task automatic tick();
		@(posedge clk);
		n--;
		if (n <= 0) begin
			chk("wait bound", 24'h1, 24'h0);
			wrap_up();
		end
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		spiMode = 1'b0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 3'h0;
		regWrData = 8'h00;
		resetPinN = 1'b1;
		clockFaultIn = 1'b0;
		adcInL = 24'h123456;
		adcInR = 24'h654321;
		adcPeakInLeft = 3'h0;
		adcPeakInRight = 3'h0;
		srcMode = 2'h1;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		n = 10;
		while (calibrationRunning !== 1'b1) tick();
		rchk(ADDR_ADC, 8'h02);
		n = 60;
		while (calibrationRunning !== 1'b0) tick();
		for (int a = 0; a < 8; a++) rchk(a[2:0], 8'h00);
		for (int i = 0; i < 6; i++) begin
			wr(addr[i], 8'hFF);
			rchk(addr[i], mask[i]);
		end
		wr(ADDR_DAC, 8'h00);
		chk("adc left", adcOutL, 24'h0);
		wr(ADDR_ADC, 8'h28);
		@(posedge clk);
		chk("adc pins", {adcPowerDown, rightHighpassDefeat, leftHighpassDefeat}, 3'h1);
		chk("adc left", adcOutL, 24'h0);
		chk("adc right", adcOutR, adcInR);
		wr(ADDR_ADC, 8'h80);
		@(posedge clk);
		chk("adc pins", {adcPowerDown, rightHighpassDefeat, leftHighpassDefeat}, 3'h4);
		chk("adc left", adcOutL, adcInL);
		wr(ADDR_ADC, 8'h00);
		for (int c = 0; c < 4; c++) begin
			f = {c[1:0], c[0], c[1:0], c[1:0], c[1:0]};
			wr(ADDR_PORT, {1'b0, f[8:2]});
			wr(ADDR_MCLK, {6'h00, f[1:0]});
			g = {deemphasisSelect, bitClockPolarity, outputFormat, inputFormat, masterClockRatio};
			chk("format fields", g, f);
		end
		spiMode <= 1'b1;
		wr(ADDR_PORT, 8'h15);
		rchk(ADDR_PORT, 8'h00);
		chk("spi write", outputFormat, 2'h1);
		spiMode <= 1'b0;
		rchk(ADDR_PORT, 8'h15);
		clockFaultIn <= 1'b1;
		repeat (4) @(posedge clk);
		rchk(ADDR_ADC, 8'h01);
		clockFaultIn <= 1'b0;
		repeat (4) @(posedge clk);
		rchk(ADDR_ADC, 8'h00);
		adcPeakInLeft <= 3'h5;
		adcPeakInRight <= 3'h3;
		@(posedge clk);
		adcPeakInLeft <= 3'h2;
		adcPeakInRight <= 3'h0;
		rchk(ADDR_STATUS, 8'h1D);
		adcPeakInLeft <= 3'h0;
		rchk(ADDR_STATUS, 8'h02);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_DAC, 8'(c));
			wr(ADDR_ATT_LEFT, 8'(2 * c + 2));
			rchk(ADDR_STATUS, 8'h40);
			n = 800;
			while (leftAppliedAtten !== 8'(2 * c + 1)) tick();
			t = 0;
			while (leftAppliedAtten !== 8'(2 * c + 2)) begin
				tick();
				t++;
			end
			chk("step period", 24'(t), 24'(per[c] * 8));
			repeat (2) @(posedge clk);
			rchk(ADDR_STATUS, 8'h00);
		end
		wr(ADDR_DAC, 8'h11);
		n = 7600;
		while (leftDacMuted !== 1'b1) tick();
		chk("manual mute", leftAppliedAtten, MUTE_CODE);
		wr(ADDR_ATT_LEFT, 8'hE3);
		wr(ADDR_DAC, 8'h01);
		n = 200;
		while (leftAppliedAtten !== 8'hE3) tick();
		chk("deepest level", leftDacMuted, 1'b0);
		wr(ADDR_ATT_LEFT, 8'hE4);
		n = 200;
		while (leftDacMuted !== 1'b1) tick();
		chk("mute code", leftAppliedAtten, 8'hE4);
		wr(ADDR_DAC, 8'h08);
		wr(ADDR_ATT_RIGHT, 8'h10);
		rchk(ADDR_STATUS, 8'h80);
		repeat (3920) @(posedge clk);
		chk("no crossing yet", rightAppliedAtten, 8'h00);
		n = 400;
		while (rightAppliedAtten !== 8'h10) tick();
		rchk(ADDR_STATUS, 8'h00);
		srcMode <= 2'h2;
		wr(ADDR_ATT_LEFT, 8'h00);
		n = 40;
		while (leftAppliedAtten !== 8'h00) tick();
		chk("crossing", leftDacMuted, 1'b0);
		srcMode <= 2'h0;
		wr(ADDR_DAC, 8'h48);
		repeat (4000) @(posedge clk);
		chk("zero run early", {leftDacMuted, rightDacMuted}, 2'h0);
		n = 200;
		while ({leftDacMuted, rightDacMuted} !== 2'h3) tick();
		chk("zero run", rightAppliedAtten, MUTE_CODE);
		srcMode <= 2'h2;
		n = 60;
		while ({leftDacMuted, rightDacMuted} !== 2'h0) tick();
		chk("release", {leftAppliedAtten, rightAppliedAtten}, 16'h0010);
		wr(ADDR_ADC, 8'h04);
		resetPinN <= 1'b0;
		repeat (4) @(posedge clk);
		resetPinN <= 1'b1;
		n = 10;
		while (calibrationRunning !== 1'b1) tick();
		n = 60;
		while (calibrationRunning !== 1'b0) tick();
		wr(ADDR_ADC, 8'h00);
		resetPinN <= 1'b0;
		repeat (4) @(posedge clk);
		resetPinN <= 1'b1;
		repeat (10) @(posedge clk);
		chk("no restart", calibrationRunning, 1'b0);
		wrap_up();
	end
endmodule

// File: bench/frame_source.sv
// Behavioural audio source: free-running frame clock and DAC samples.
// Assumes the bench picks the pattern: 0 zeros, 1 steady positive, 2 alternating sign.
`timescale 1ns/1ps

module frame_source
	import codec_ctrl_pkg::*;
(
	input  wire logic [1:0]          mode,
	output logic                     frameLrClock,
	output logic      [SAMPLE_W-1:0] sampleLeft,
	output logic      [SAMPLE_W-1:0] sampleRight
);
	logic sign = 1'b0;

	// Frame clock of 200 ns, phase unrelated to the system clock
	initial begin
		frameLrClock = 1'b0;
		sampleLeft = '0;
		#37;
		forever #100 frameLrClock = ~frameLrClock;
	end

	// New sample at each frame start, held for the whole frame
	always @(posedge frameLrClock) begin
		sign <= ~sign;
		case (mode)
			2'h0: sampleLeft <= '0;
			2'h1: sampleLeft <= 24'h000100;
			default: sampleLeft <= sign ? 24'hFFFF00 : 24'h000100;
		endcase
	end

	assign sampleRight = sampleLeft;
endmodule

// File: common/codec_ctrl_pkg.sv
// Constants, register map and state types for the codec control register bank.
// Assumes a 40 MHz system clock and an 8-bit register port decoded upstream.
package codec_ctrl_pkg;

	// Register offsets
	localparam logic [2:0] ADDR_RESERVED = 3'h0;
	localparam logic [2:0] ADDR_ADC      = 3'h1;
	localparam logic [2:0] ADDR_DAC      = 3'h2;
	localparam logic [2:0] ADDR_ATT_LEFT = 3'h3;
	localparam logic [2:0] ADDR_ATT_RIGHT = 3'h4;
	localparam logic [2:0] ADDR_PORT     = 3'h5;
	localparam logic [2:0] ADDR_STATUS   = 3'h6;
	localparam logic [2:0] ADDR_MCLK     = 3'h7;

	// Reset values
	localparam logic [7:0] RST_ADC  = 8'h00;
	localparam logic [7:0] RST_DAC  = 8'h00;
	localparam logic [7:0] RST_ATT  = 8'h00;
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_MCLK = 8'h00;

	// Writable bits of each register; the rest are reserved or read-only
	localparam logic [7:0] WMASK_ADC  = 8'hFC;
	localparam logic [7:0] WMASK_DAC  = 8'h7B;
	localparam logic [7:0] WMASK_PORT = 8'h7F;
	localparam logic [7:0] WMASK_MCLK = 8'h03;

	// ADC setup fields
	localparam int ADC_PDN_BIT  = 7;
	localparam int ADC_HPD_BIT0 = 5; // Left, right is one above
	localparam int ADC_MUTE_BIT0 = 3; // Left, right is one above
	localparam int ADC_CAL_BIT  = 2;
	localparam int ADC_CALIBRATION_RUNNING_BIT = 1;
	localparam int ADC_CLOCKING_FAULT_BIT = 0;

	// DAC setup fields
	localparam int DAC_ZMUTE_BIT = 6;
	localparam int DAC_MUTE_BIT0 = 4; // Left, right is one above
	localparam int DAC_SOFT_BIT  = 3;
	localparam int DAC_RMP_LSB   = 0;

	// Serial port format fields
	localparam int PORT_DEM_LSB = 5;
	localparam int PORT_BIT_CLOCK_POLARITY_BIT = 4;
	localparam int PORT_DOF_LSB = 2;
	localparam int PORT_DIF_LSB = 0;

	// Status fields
	localparam int STAT_ACC_BIT0 = 6; // Left, right is one above
	localparam int STAT_LVL_LSB0 = 0; // Left peak, right at 3

	// Level and timing
	localparam logic [7:0] MUTE_CODE = 8'hE4;
	localparam logic [8:0] ZERO_RUN_LEN = 9'h1FF; // Last count of 512 samples
	localparam logic [8:0] ZC_TIMEOUT = 9'h1FF;   // Last count of 512 samples
	localparam logic [5:0] RAMP_PER_00 = 6'h08;
	localparam logic [5:0] RAMP_PER_01 = 6'h04;
	localparam logic [5:0] RAMP_PER_10 = 6'h10;
	localparam logic [5:0] RAMP_PER_11 = 6'h20;
	localparam int SAMPLE_W = 24;

	localparam longint CLK_HZ = 40000000;
	localparam longint CAL_TIME_MS = 50;
	localparam longint CAL_CYCLES = (CLK_HZ * CAL_TIME_MS) / 1000;
	localparam int CAL_CNT_W = 21;

	// Calibration sequencer states
	typedef enum logic [1:0] {
		CAL_IDLE = 2'b00,
		CAL_RUN  = 2'b01
	} cal_state_t;

endpackage

// File: rtl/codec_ctrl_regs.sv
// Control register bank of a stereo audio codec with volume ramping and muting.
// Assumes a control port front end on clk that decodes I2C or SPI into register
// strobes, and a serial audio port that presents whole samples on clk.
//
// Function
// [R1] Registers read and write in I2C mode; SPI mode allows writes only.
// [R2] ADC power-down bit drives the converter low-power output.
// [R3] Per-channel high-pass defeat bits bypass only that channel's filter.
// [R4] ADC mute bit forces that channel's converted data to zero.
// [R5] 50 ms offset calibration after reset; with CAL set, reset pin rise restarts it.
// [R6] Calibration status reads 1 while calibrating, 0 when done.
// [R7] Clocking-error bit reads the present fault, resets to 0.
// [R8] Zero-run mute after 512 static samples per channel; any other sample releases.
// [R9] Manual and zero-run mutes follow the selected ramp or zero-cross method.
// [R10] Soft mode steps 0.5 dB toward target, default every 8 frames.
// [R11] Zero-cross mode jumps at next crossing, forced after 512 samples.
// [R12] Acceptance bits report per channel when the level change applied.
// [R13] Ramp rate codes 00..11 give one step per 8, 4, 16, 32 frames.
// [R14] Per-channel 8-bit attenuation, 0.5 dB per count, up to 113.5 dB.
// [R15] Attenuation codes from 228 upward fully mute the output.
// [R16] De-emphasis field selects 44.1, 48, 32 kHz or off.
// [R17] Bit clock polarity picks rising or falling data edge.
// [R18] Output format field selects I2S, left, right 24-bit, right 20-bit.
// [R19] Right-justified slave mode needs a 64 Fs bit clock from outside.
// [R20] Input format field selects I2S, left, right 24-bit, right 20-bit.
// [R21] Acceptance bit rises on attenuation load, falls when level reached.
// [R22] Peak level fields hold maximum since last status read, cleared by it.
// [R23] Master clock field selects 256, 384 or 512 Fs in master mode.
// [R24] Reserved bits and offset zero ignore writes and read zero; fields reset to zero.
// [R25] Writes to read-only status bits have no effect.
`timescale 1ns/1ps

module codec_ctrl_regs
	import codec_ctrl_pkg::*;
#(
	parameter longint CalCycles = CAL_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                spiMode,
	input  wire logic [2:0]          regAddr,
	input  wire logic                regWrEn,
	input  wire logic [7:0]          regWrData,
	input  wire logic                regRdEn,
	output logic      [7:0]          regRdData,
	input  wire logic                frameLrClock,
	input  wire logic                resetPinN,
	input  wire logic                clockFaultIn,
	input  wire logic [SAMPLE_W-1:0] dacSampleLeft,
	input  wire logic [SAMPLE_W-1:0] dacSampleRight,
	input  wire logic [SAMPLE_W-1:0] adcSampleInLeft,
	input  wire logic [SAMPLE_W-1:0] adcSampleInRight,
	input  wire logic [2:0]          adcPeakInLeft,
	input  wire logic [2:0]          adcPeakInRight,
	output logic      [SAMPLE_W-1:0] adcSampleOutLeft,
	output logic      [SAMPLE_W-1:0] adcSampleOutRight,
	output logic                     adcPowerDown,
	output logic                     leftHighpassDefeat,
	output logic                     rightHighpassDefeat,
	output logic      [1:0]          deemphasisSelect,
	output logic                     bitClockPolarity,
	output logic      [1:0]          outputFormat,
	output logic      [1:0]          inputFormat,
	output logic      [1:0]          masterClockRatio,
	output logic                     calibrationRunning,
	output logic      [7:0]          leftAppliedAtten,
	output logic      [7:0]          rightAppliedAtten,
	output logic                     leftDacMuted,
	output logic                     rightDacMuted
);

	localparam logic [CAL_CNT_W-1:0] CAL_LAST = CAL_CNT_W'(CalCycles - 1);

	logic                 rstSync1_q;
	logic                 rstSync2_q;
	logic                 rstnInt;
	logic                 lrSync1_q;
	logic                 lrSync2_q;
	logic                 lrPrev_q;
	logic                 rpSync1_q;
	logic                 rpSync2_q;
	logic                 rpPrev_q;
	logic                 cfSync1_q;
	logic                 cfSync2_q;
	logic                 frameTick;
	logic                 resetPinRise;
	logic [7:0]           adcCtl_q;
	logic [7:0]           dacCtl_q;
	logic [7:0]           attReg_q [2];
	logic [7:0]           portCtl_q;
	logic [7:0]           mclkCtl_q;
	logic [1:0]           accepted_q;
	logic [2:0]           peak_q [2];
	logic [7:0]           applied_q [2];
	logic [SAMPLE_W-1:0]  adcOut_q [2];
	logic [SAMPLE_W-1:0]  dacIn [2];
	logic [SAMPLE_W-1:0]  adcIn [2];
	logic [2:0]           peakIn [2];
	logic                 wrAccept;
	logic                 statusRead;
	logic [7:0]           statusVal;
	logic [7:0]           rdMux;
	logic [5:0]           rampPeriod;
	logic [5:0]           rampCnt_q;
	logic                 stepTick;
	logic                 softZeroCross;
	cal_state_t           calState_q;
	logic [CAL_CNT_W-1:0] calCnt_q;
	logic                 bootCal_q;

	// Reset release through two flip-flops
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rstSync1_q <= 1'b0;
			rstSync2_q <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstSync2_q <= rstSync1_q;
		end
	end
	assign rstnInt = rstSync2_q;

	// Synchronisers for frame clock, reset pin and clock fault level
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			lrSync1_q <= 1'b0;
			lrSync2_q <= 1'b0;
			lrPrev_q  <= 1'b0;
			rpSync1_q <= 1'b1; // Idle level of the reset pin, no false rise
			rpSync2_q <= 1'b1;
			rpPrev_q  <= 1'b1;
			cfSync1_q <= 1'b0;
			cfSync2_q <= 1'b0;
		end else begin
			lrSync1_q <= frameLrClock;
			lrSync2_q <= lrSync1_q;
			lrPrev_q  <= lrSync2_q;
			rpSync1_q <= resetPinN;
			rpSync2_q <= rpSync1_q;
			rpPrev_q  <= rpSync2_q;
			cfSync1_q <= clockFaultIn;
			cfSync2_q <= cfSync1_q;
		end
	end
	assign frameTick    = lrSync2_q & ~lrPrev_q;
	assign resetPinRise = rpSync2_q & ~rpPrev_q;

	// Bus strobes; reads exist only on the I2C port
	assign wrAccept   = regWrEn;
	assign statusRead = regRdEn & ~spiMode & (regAddr == ADDR_STATUS); // [R1] [R22]

	// Control registers, reserved and read-only bits masked off
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			adcCtl_q    <= RST_ADC; // [R24]
			dacCtl_q    <= RST_DAC;
			attReg_q[0] <= RST_ATT;
			attReg_q[1] <= RST_ATT;
			portCtl_q   <= RST_PORT;
			mclkCtl_q   <= RST_MCLK;
		end else if (wrAccept) begin
			case (regAddr)
				ADDR_ADC:       adcCtl_q    <= regWrData & WMASK_ADC; // [R24] [R25]
				ADDR_DAC:       dacCtl_q    <= regWrData & WMASK_DAC; // [R24]
				ADDR_ATT_LEFT:  attReg_q[0] <= regWrData; // [R14]
				ADDR_ATT_RIGHT: attReg_q[1] <= regWrData; // [R14]
				ADDR_PORT:      portCtl_q   <= regWrData & WMASK_PORT; // [R24]
				ADDR_MCLK:      mclkCtl_q   <= regWrData & WMASK_MCLK; // [R24]
				default: ; // Offset zero and status ignore writes
			endcase
		end
	end

	// Status register image
	assign statusVal = {accepted_q[1], accepted_q[0], peak_q[1], peak_q[0]};

	// Read multiplexer
	always_comb begin
		case (regAddr)
			ADDR_ADC:       rdMux = {adcCtl_q[7:2], calibrationRunning, cfSync2_q}; // [R6] [R7]
			ADDR_DAC:       rdMux = dacCtl_q;
			ADDR_ATT_LEFT:  rdMux = attReg_q[0];
			ADDR_ATT_RIGHT: rdMux = attReg_q[1];
			ADDR_PORT:      rdMux = portCtl_q;
			ADDR_STATUS:    rdMux = statusVal;
			ADDR_MCLK:      rdMux = mclkCtl_q;
			default:        rdMux = 8'h00; // [R24]
		endcase
	end

	// Read data register; SPI mode gives no readback
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			regRdData <= 8'h00;
		end else if (regRdEn) begin
			regRdData <= spiMode ? 8'h00 : rdMux; // [R1]
		end
	end

	// Plain control outputs straight from the registers
	assign adcPowerDown        = adcCtl_q[ADC_PDN_BIT]; // [R2]
	assign leftHighpassDefeat  = adcCtl_q[ADC_HPD_BIT0]; // [R3]
	assign rightHighpassDefeat = adcCtl_q[ADC_HPD_BIT0 + 1]; // [R3]
	assign deemphasisSelect    = portCtl_q[PORT_DEM_LSB +: 2]; // [R16]
	assign bitClockPolarity    = portCtl_q[PORT_BIT_CLOCK_POLARITY_BIT]; // [R17]
	assign outputFormat        = portCtl_q[PORT_DOF_LSB +: 2]; // [R18] [R19]
	assign inputFormat         = portCtl_q[PORT_DIF_LSB +: 2]; // [R20]
	assign masterClockRatio    = mclkCtl_q[1:0]; // [R23]

	// Calibration sequencer: once after reset, again on reset pin rise when enabled
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			calState_q <= CAL_IDLE;
			calCnt_q   <= '0;
			bootCal_q  <= 1'b1;
		end else begin
			case (calState_q)
				CAL_IDLE: begin
					if (bootCal_q || (adcCtl_q[ADC_CAL_BIT] && resetPinRise)) begin // [R5]
						calState_q <= CAL_RUN;
						calCnt_q   <= '0;
						bootCal_q  <= 1'b0;
					end
				end
				CAL_RUN: begin
					if (calCnt_q == CAL_LAST) begin // [R5]
						calState_q <= CAL_IDLE;
					end else begin
						calCnt_q <= calCnt_q + 1'b1;
					end
				end
				default: calState_q <= CAL_IDLE;
			endcase
		end
	end
	assign calibrationRunning = (calState_q == CAL_RUN); // [R6]

	// Ramp step period from the rate field
	always_comb begin
		case (dacCtl_q[DAC_RMP_LSB +: 2])
			2'b00:   rampPeriod = RAMP_PER_00; // [R13]
			2'b01:   rampPeriod = RAMP_PER_01; // [R13]
			2'b10:   rampPeriod = RAMP_PER_10; // [R13]
			default: rampPeriod = RAMP_PER_11; // [R13]
		endcase
	end

	// Frame counter giving one step tick per ramp period
	always_ff @(posedge clk or negedge rstnInt) begin
		if (!rstnInt) begin
			rampCnt_q <= '0;
		end else if (frameTick) begin
			rampCnt_q <= (rampCnt_q >= rampPeriod - 6'h01) ? 6'h00 : rampCnt_q + 6'h01; // [R10]
		end
	end
	assign stepTick      = frameTick && (rampCnt_q >= rampPeriod - 6'h01); // [R10] [R13]
	assign softZeroCross = dacCtl_q[DAC_SOFT_BIT];

	assign dacIn[0]  = dacSampleLeft;
	assign dacIn[1]  = dacSampleRight;
	assign adcIn[0]  = adcSampleInLeft;
	assign adcIn[1]  = adcSampleInRight;
	assign peakIn[0] = adcPeakInLeft;
	assign peakIn[1] = adcPeakInRight;

	// Per-channel level control, zero-run mute, ADC mute and peak capture
	for (genvar c = 0; c < 2; c++) begin : gChan
		logic [8:0]          zeroRun_q;
		logic                zeroMute_q;
		logic [8:0]          zcWait_q;
		logic                prevSign_q;
		logic [7:0]          target;
		logic                pending;
		logic                isStatic;
		logic                crossing;
		logic [SAMPLE_W-1:0] sample;
		logic [2:0]          attAddr;

		assign sample   = dacIn[c];
		assign attAddr  = (c == 0) ? ADDR_ATT_LEFT : ADDR_ATT_RIGHT;
		assign isStatic = (sample == {SAMPLE_W{1'b0}}) || (sample == {SAMPLE_W{1'b1}});
		assign crossing = (sample[SAMPLE_W-1] != prevSign_q) || (sample == {SAMPLE_W{1'b0}});

		// Target level: any mute source or a code past the range drives full mute
		always_comb begin
			if (dacCtl_q[DAC_MUTE_BIT0 + c] || zeroMute_q) begin // [R9]
				target = MUTE_CODE;
			end else if (attReg_q[c] >= MUTE_CODE) begin // [R15]
				target = MUTE_CODE;
			end else begin
				target = attReg_q[c]; // [R14]
			end
		end
		assign pending = (applied_q[c] != target);

		// Zero-run detector counts static samples per frame
		always_ff @(posedge clk or negedge rstnInt) begin
			if (!rstnInt) begin
				zeroRun_q  <= '0;
				zeroMute_q <= 1'b0;
				prevSign_q <= 1'b0;
			end else if (frameTick) begin
				prevSign_q <= sample[SAMPLE_W-1];
				if (!dacCtl_q[DAC_ZMUTE_BIT] || !isStatic) begin
					zeroRun_q  <= '0;
					zeroMute_q <= 1'b0; // [R8]
				end else if (zeroRun_q == ZERO_RUN_LEN) begin
					zeroMute_q <= 1'b1; // [R8]
				end else begin
					zeroRun_q <= zeroRun_q + 9'h001;
				end
			end
		end

		// Applied level: soft ramp one count per tick, or jump at crossing or timeout
		always_ff @(posedge clk or negedge rstnInt) begin
			if (!rstnInt) begin
				applied_q[c] <= RST_ATT;
				zcWait_q     <= '0;
			end else if (!pending) begin
				zcWait_q <= '0;
			end else if (!softZeroCross) begin
				zcWait_q <= '0;
				if (stepTick) begin
					applied_q[c] <= (applied_q[c] < target) ? applied_q[c] + 8'h01
					                                        : applied_q[c] - 8'h01; // [R10]
				end
			end else if (frameTick) begin
				if (crossing || zcWait_q == ZC_TIMEOUT) begin
					applied_q[c] <= target; // [R11]
					zcWait_q     <= '0;
				end else begin
					zcWait_q <= zcWait_q + 9'h001; // [R11]
				end
			end
		end

		// Acceptance flag: load sets it, reaching the target clears it, load wins
		always_ff @(posedge clk or negedge rstnInt) begin
			if (!rstnInt) begin
				accepted_q[c] <= 1'b0;
			end else if (wrAccept && regAddr == attAddr) begin
				accepted_q[c] <= 1'b1; // [R21]
			end else if (!pending) begin
				accepted_q[c] <= 1'b0; // [R12] [R21]
			end
		end

		// Sticky peak level, cleared by a status read; a new peak wins
		always_ff @(posedge clk or negedge rstnInt) begin
			if (!rstnInt) begin
				peak_q[c] <= 3'h0;
			end else if (statusRead) begin
				peak_q[c] <= peakIn[c]; // [R22]
			end else if (peakIn[c] > peak_q[c]) begin
				peak_q[c] <= peakIn[c]; // [R22]
			end
		end

		// ADC output data with per-channel mute
		always_ff @(posedge clk or negedge rstnInt) begin
			if (!rstnInt) begin
				adcOut_q[c] <= '0;
			end else begin
				adcOut_q[c] <= adcCtl_q[ADC_MUTE_BIT0 + c] ? '0 : adcIn[c]; // [R4]
			end
		end
	end

	assign adcSampleOutLeft  = adcOut_q[0];
	assign adcSampleOutRight = adcOut_q[1];
	assign leftAppliedAtten  = applied_q[0];
	assign rightAppliedAtten = applied_q[1];
	assign leftDacMuted      = (applied_q[0] >= MUTE_CODE); // [R15]
	assign rightDacMuted     = (applied_q[1] >= MUTE_CODE); // [R15]

endmodule
